// >>> atm_layer_model.sv
// model: atm layer side popping one whole cell from the receive fifo
`timescale 1ns/1ns
`default_nettype none
module atm_layer_model (
   input wire logic i_clk,
   input wire logic i_go,
   input wire logic i_slow,
   input wire logic i_avail,
   input wire logic [7:0] i_data,
   input wire logic i_parity,
   input wire logic i_valid,
   output logic o_read,
   output logic o_done
);
   logic [7:0] rx [0:52];
   logic par [0:52];
   logic rd_q = 1'b0;
   logic tick = 1'b0;
   int cnt = 0;
   int got = 0;
   int nxt;
   assign o_read = rd_q;
   assign o_done = (got == 53);
   // slow mode drops every other read so the fifo sees stalls
   always @(posedge i_clk) begin
      tick <= ~tick;
      nxt = cnt + ((rd_q && i_avail) ? 1 : 0);
      cnt <= i_go ? nxt : 0;
      rd_q <= i_go && nxt < 53 && !(i_slow && tick);
      if (!i_go) begin
         got <= 0;
      end else if (i_valid && got < 53) begin
         rx[got] <= i_data;
         par[got] <= i_parity;
         got <= got + 1;
      end
   end
endmodule // atm_layer_model
`default_nettype wire

// >>> cell_fifo.sv
// module: four-cell receive fifo and its byte read port
`timescale 1ns/1ns
`default_nettype none
module cell_fifo (
   input wire logic i_clk,
   input wire logic i_reset_n,
   cell_fifo_if.store f,
   input wire logic i_read,
   input wire logic i_parity_even,
   output logic [7:0] o_data,
   output logic o_parity,
   output logic o_valid,
   output logic o_soc,
   output logic o_avail
);
   import cell_proc_pkg::*;
   logic [39:0] hdr_mem [0:3];
   logic [7:0] pay_mem [0:191];
   logic [1:0] wr_slot;
   logic [1:0] rd_slot;
   logic [5:0] rd_idx;
   logic [7:0] rd_byte;
   logic pop;
   logic pop_last;

   function automatic logic [7:0] slot_addr(input logic [1:0] s, input logic [5:0] i);
      return 8'(int'(s) * pay_len + int'(i));
   endfunction

   assign pop = i_read && f.count != 3'h0 && !f.flush;
   assign pop_last = pop && rd_idx == last_idx;
   assign rd_byte = (rd_idx < pay_first) ? hdr_mem[rd_slot][8 * (4 - int'(rd_idx)) +: 8]
                                         : pay_mem[slot_addr(rd_slot, rd_idx - pay_first)];

   // memories carry no reset; only committed slots are ever read
   always_ff @(posedge i_clk) begin
      if (f.hdr_we) begin
         hdr_mem[wr_slot] <= f.hdr_data;
      end
      if (f.pay_we) begin
         pay_mem[slot_addr(wr_slot, f.pay_idx)] <= f.pay_data;
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         wr_slot <= 2'h0;
         rd_slot <= 2'h0;
         rd_idx <= 6'h0;
         f.count <= 3'h0;
      end else if (f.flush) begin
         wr_slot <= 2'h0;
         rd_slot <= 2'h0;
         rd_idx <= 6'h0;
         f.count <= 3'h0;
      end else begin
         if (f.commit) begin
            wr_slot <= wr_slot + 2'h1;
         end
         if (pop) begin
            rd_idx <= pop_last ? 6'h0 : rd_idx + 6'h1;
         end
         if (pop_last) begin
            rd_slot <= rd_slot + 2'h1;
         end
         f.count <= f.count + {2'b00, f.commit} - {2'b00, pop_last};
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_data <= 8'h00;
         o_parity <= 1'b1;
         o_valid <= 1'b0;
         o_soc <= 1'b0;
         o_avail <= 1'b0;
      end else begin
         o_valid <= pop;
         o_soc <= pop && rd_idx == 6'h0;
         o_avail <= f.count != 3'h0 && !f.flush;
         if (pop) begin
            o_data <= rd_byte;
            o_parity <= i_parity_even ? ^rd_byte : ~^rd_byte;
         end
      end
   end
endmodule // cell_fifo
`default_nettype wire

// >>> cell_fifo_if.sv
// interface: write side of the cell fifo
`timescale 1ns/1ns
`default_nettype none
interface cell_fifo_if;
   logic flush;
   logic hdr_we;
   logic [39:0] hdr_data;
   logic pay_we;
   logic [5:0] pay_idx;
   logic [7:0] pay_data;
   logic commit;
   logic [2:0] count;
   modport writer(output flush, hdr_we, hdr_data, pay_we, pay_idx, pay_data, commit,
                  input count);
   modport store(input flush, hdr_we, hdr_data, pay_we, pay_idx, pay_data, commit,
                 output count);
endinterface
`default_nettype wire

// >>> cell_proc_pkg.sv
// package: register map, fields and constants of the receive cell processor
// How it works
// - flush empties fifo and blocks writes
// - descramble payload unless disabled
// - optional coset added before header compare
// - uncorrectable header cells dropped unless pass
// - pass keeps errored cells, correction mode held
// - no cells kept in hunt or presync
// - single-bit header errors corrected when enabled
// - correction off makes every error uncorrectable
// - idle cell filter drops matching cells
// - bypass switches idle filtering off entirely
// - parity even or odd over output byte
// - status bit shows out of delineation
// - overrun flag set, cleared by reading
// - correctable and uncorrectable flags, read clears
// - delineation change flag on sync entry/loss
// - interrupt sources gated by enable bits
// - pattern covers flow, type, priority bits
// - idle needs zero path/channel and match
// - mask one compares, zero ignores
// - reset values drop zero path/channel cells
// - detection mode needs 1/2/4/8 clean cells
// - cell count covers only fifo writes
package cell_proc_pkg;
   localparam logic [9:0] idx_ctrl = 10'h050;
   localparam logic [9:0] idx_irq = 10'h051;
   localparam logic [9:0] idx_pattern = 10'h052;
   localparam logic [9:0] idx_mask = 10'h053;
   localparam logic [9:0] idx_config = 10'h05a;
   localparam logic [9:0] idx_count = 10'h05b;
   localparam logic [6:0] ctrl_reset = 7'h04;
   localparam logic [7:0] pattern_reset = 8'h00;
   localparam logic [7:0] mask_reset = 8'h00;
   localparam logic [1:0] thr_reset = 2'h0;
   localparam int bit_flush = 0;
   localparam int bit_descr_off = 1;
   localparam int bit_coset = 2;
   localparam int bit_pass = 3;
   localparam int bit_corr_off = 4;
   localparam int bit_bypass = 5;
   localparam int bit_parity = 6;
   localparam logic [5:0] hec_idx = 6'h04;
   localparam logic [5:0] pay_first = 6'h05;
   localparam logic [5:0] last_idx = 6'h34;
   localparam int pay_len = 48;
   localparam logic [2:0] slots = 3'h4;
   localparam logic [2:0] alpha_m1 = 3'h6;
   localparam logic [2:0] delta_m1 = 3'h5;
   localparam logic [7:0] coset_pattern = 8'h55;
   localparam logic [7:0] crc_poly = 8'h07;

   typedef enum logic [1:0] {hunt = 2'b00, presync = 2'b01, sync = 2'b10} delin_state_type;
   typedef enum logic {correct_mode = 1'b0, detect_mode = 1'b1} hdr_mode_type;

   function automatic logic [7:0] crc8(input logic [31:0] d);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 31; i >= 0; i--) begin
         c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? crc_poly : 8'h00);
      end
      return c;
   endfunction

   // syndrome left by a single flipped bit at position p of the header
   function automatic logic [7:0] unit_syn(input int p);
      if (p < 8) begin
         return 8'h01 << p;
      end
      return crc8(32'h1 << (p - 8));
   endfunction
endpackage

// >>> hec_check.sv
// module: header check syndrome and single-bit correction
`timescale 1ns/1ns
`default_nettype none
module hec_check (
   input wire logic [39:0] i_hdr,
   input wire logic i_coset_add,
   input wire logic i_correct_en,
   output logic o_clean,
   output logic o_correctable,
   output logic [39:0] o_fixed
);
   import cell_proc_pkg::*;
   logic [7:0] syn;
   always_comb begin
      syn = crc8(i_hdr[39:8]) ^ i_hdr[7:0] ^ (i_coset_add ? coset_pattern : 8'h00);
      o_clean = syn == 8'h00;
      o_correctable = 1'b0;
      o_fixed = i_hdr;
      for (int p = 0; p < 40; p++) begin
         if (i_correct_en && !o_clean && syn == unit_syn(p)) begin
            o_correctable = 1'b1;
            o_fixed[p] = ~i_hdr[p];
         end
      end
   end
endmodule // hec_check
`default_nettype wire

// >>> rx_atm_cell_processor.sv
// top: receive cell delineation, header check, filter, descrambler and registers
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ns
`default_nettype none
module rx_atm_cell_processor (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [3:0] i_pstrb,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic [7:0] i_cell_byte,
   input wire logic i_cell_valid,
   input wire logic i_rx_read,
   output logic [7:0] o_rx_cell_bus,
   output logic o_rx_parity_out,
   output logic o_rx_valid,
   output logic o_rx_start_of_cell,
   output logic o_rx_cell_avail,
   output logic o_irq
);
   import cell_proc_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // reset release
   logic rst_meta;
   logic rst_n;
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // declarations
   cell_fifo_if f();
   logic [6:0] ctrl;
   logic [2:0] irq_en;
   logic [3:0] flags;
   logic [3:0] flag_set;
   logic [3:0] flags_seen;
   logic [7:0] pattern;
   logic [7:0] mask;
   logic [1:0] thr_code;
   logic [18:0] cell_count;
   logic [18:0] cnt_seen;
   logic rx_flush;
   logic setup;
   logic access;
   logic wr_acc;
   logic rd_acc;
   logic mapped;
   logic [9:0] widx;
   logic [31:0] rd_value;
   delin_state_type delin;
   logic [5:0] idx;
   logic [2:0] run_good;
   logic [2:0] run_bad;
   logic at_hdr;
   logic cell_dec;
   logic to_hunt;
   logic to_sync;
   logic in_payload;
   logic [39:0] win;
   logic [39:0] hdr_now;
   logic clean;
   logic correctable;
   logic [39:0] fixed;
   hdr_mode_type mode;
   hdr_mode_type next_mode;
   logic [3:0] run_ok;
   logic [3:0] next_run;
   logic [3:0] thr;
   logic accept;
   logic corr_evt;
   logic uncorr_evt;
   logic idle;
   logic keep_now;
   logic keep;
   logic ovr_evt;
   logic [42:0] scr_hist;
   logic [42:0] next_hist;
   logic [7:0] descr_byte;

   assign rx_flush = ctrl[bit_flush];

   ////////////////////////////////////////////////////////////////////////
   // apb slave: zero wait states, data captured in setup
   assign widx = i_paddr[11:2];
   assign setup = i_psel && !i_penable;
   assign access = i_psel && i_penable && o_pready;
   assign wr_acc = access && i_pwrite && i_pstrb[0];
   assign rd_acc = access && !i_pwrite;

   always_comb begin
      mapped = 1'b1;
      rd_value = 32'h0;
      case (widx)
         idx_ctrl: rd_value[7:0] = {delin != sync, ctrl};
         idx_irq: rd_value[7:0] = {irq_en, flags, 1'b0};
         idx_pattern: rd_value[7:0] = pattern;
         idx_mask: rd_value[7:0] = mask;
         idx_config: rd_value[1:0] = thr_code;
         idx_count: rd_value[18:0] = cell_count;
         default: mapped = 1'b0;
      endcase
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata <= 32'h0;
         flags_seen <= 4'h0;
         cnt_seen <= 19'h0;
      end else begin
         o_pready <= setup;
         o_pslverr <= setup && !mapped;
         if (setup) begin
            o_prdata <= i_pwrite ? 32'h0 : rd_value;
            flags_seen <= (!i_pwrite && widx == idx_irq) ? flags : 4'h0;
            cnt_seen <= (!i_pwrite && widx == idx_count) ? cell_count : 19'h0;
         end
      end
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl <= ctrl_reset;
         irq_en <= 3'h0;
         pattern <= pattern_reset;
         mask <= mask_reset;
         thr_code <= thr_reset;
      end else if (wr_acc) begin
         case (widx)
            idx_ctrl: ctrl <= i_pwdata[6:0];
            idx_irq: irq_en <= i_pwdata[7:5];
            idx_pattern: pattern <= i_pwdata[7:0];
            idx_mask: mask <= i_pwdata[7:0];
            idx_config: thr_code <= i_pwdata[1:0];
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // sticky flags, counter and interrupt
   // only bits shown by the read are cleared, so a set in between survives
   assign flag_set = {to_sync || to_hunt, cell_dec && corr_evt, cell_dec && uncorr_evt, ovr_evt};

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         flags <= 4'h0;
      end else begin
         flags <= (flags & ~(rd_acc ? flags_seen : 4'h0)) | flag_set;
      end
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         cell_count <= 19'h0;
      end else begin
         cell_count <= cell_count - (rd_acc ? cnt_seen : 19'h0) + {18'h0, f.commit};
      end
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_irq <= 1'b0;
      end else begin
         o_irq <= |{flags[0] & irq_en[0], (flags[1] | flags[2]) & irq_en[1],
                    flags[3] & irq_en[2]};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // cell delineation
   assign hdr_now = {win[31:0], i_cell_byte};
   assign at_hdr = i_cell_valid && (delin == hunt || idx == hec_idx);
   assign to_sync = at_hdr && delin == presync && clean && run_good == delta_m1;
   assign to_hunt = at_hdr && delin == sync && !clean && run_bad == alpha_m1;
   assign cell_dec = at_hdr && delin == sync && !to_hunt;
   assign in_payload = i_cell_valid && delin != hunt && idx >= pay_first;

   hec_check u_hec (
      .i_hdr(hdr_now),
      .i_coset_add(ctrl[bit_coset]),
      .i_correct_en(!ctrl[bit_corr_off]),
      .o_clean(clean),
      .o_correctable(correctable),
      .o_fixed(fixed)
   );

   // hunt checks every byte offset; the other states only cell boundaries
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         win <= 40'h0;
         delin <= hunt;
         idx <= 6'h0;
         run_good <= 3'h0;
         run_bad <= 3'h0;
      end else if (i_cell_valid) begin
         win <= hdr_now;
         if (delin != hunt) begin
            idx <= (idx == last_idx) ? 6'h0 : idx + 6'h1;
         end
         if (at_hdr) begin
            unique case (delin)
               hunt: begin
                  if (clean) begin
                     delin <= presync;
                     idx <= pay_first;
                     run_good <= 3'h0;
                  end
               end
               presync: begin
                  if (!clean) begin
                     delin <= hunt;
                  end else if (to_sync) begin
                     delin <= sync;
                     run_bad <= 3'h0;
                  end else begin
                     run_good <= run_good + 3'h1;
                  end
               end
               sync: begin
                  if (to_hunt) begin
                     delin <= hunt;
                  end else if (clean) begin
                     run_bad <= 3'h0;
                  end else begin
                     run_bad <= run_bad + 3'h1;
                  end
               end
               default: delin <= hunt;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // header verification: correction and detection modes
   assign thr = 4'h1 << thr_code;

   always_comb begin
      accept = 1'b0;
      corr_evt = 1'b0;
      uncorr_evt = 1'b0;
      next_mode = mode;
      next_run = run_ok;
      if (clean) begin
         if (mode == correct_mode || ctrl[bit_pass]) begin
            accept = 1'b1;
         end else if (run_ok + 4'h1 >= thr) begin
            accept = 1'b1;
            next_mode = correct_mode;
            next_run = 4'h0;
         end else begin
            next_run = run_ok + 4'h1;
         end
      end else if (correctable) begin
         corr_evt = 1'b1;
         accept = mode == correct_mode || ctrl[bit_pass];
         next_mode = detect_mode;
         next_run = 4'h0;
      end else begin
         uncorr_evt = 1'b1;
         accept = ctrl[bit_pass];
         next_mode = detect_mode;
         next_run = 4'h0;
      end
      if (ctrl[bit_pass]) begin
         next_mode = correct_mode;
      end
   end

   // zero path/channel plus masked flow/type/priority match
   assign idle = fixed[35:12] == 24'h0 &&
                 ((({fixed[39:36], fixed[11:8]} ^ pattern) & mask) == 8'h00);
   assign keep_now = cell_dec && accept && !(idle && !ctrl[bit_bypass]) && !rx_flush;
   assign ovr_evt = keep_now && f.count == slots;

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         mode <= correct_mode;
         run_ok <= 4'h0;
         keep <= 1'b0;
      end else begin
         if (cell_dec) begin
            mode <= next_mode;
            run_ok <= next_run;
         end
         if (rx_flush || f.commit) begin
            keep <= 1'b0;
         end else if (cell_dec) begin
            keep <= f.hdr_we;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // payload descrambler, self-synchronising x^43+1
   function automatic logic [50:0] descramble(input logic [42:0] h, input logic [7:0] b);
      logic [42:0] s;
      logic [7:0] o;
      s = h;
      o = 8'h00;
      for (int i = 7; i >= 0; i--) begin
         o[i] = b[i] ^ s[42];
         s = {s[41:0], b[i]};
      end
      return {s, o};
   endfunction

   assign {next_hist, descr_byte} = descramble(scr_hist, i_cell_byte);

   // history keeps running while disabled so re-enabling needs no resync
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         scr_hist <= 43'h0;
      end else if (in_payload) begin
         scr_hist <= next_hist;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // receive fifo
   assign f.flush = rx_flush;
   assign f.hdr_we = keep_now && f.count != slots;
   assign f.hdr_data = fixed;
   assign f.pay_we = keep && in_payload && !rx_flush;
   assign f.pay_idx = idx - pay_first;
   assign f.pay_data = ctrl[bit_descr_off] ? i_cell_byte : descr_byte;
   assign f.commit = f.pay_we && idx == last_idx;

   cell_fifo u_fifo (
      .i_clk(i_clk),
      .i_reset_n(rst_n),
      .f(f),
      .i_read(i_rx_read),
      .i_parity_even(ctrl[bit_parity]),
      .o_data(o_rx_cell_bus),
      .o_parity(o_rx_parity_out),
      .o_valid(o_rx_valid),
      .o_soc(o_rx_start_of_cell),
      .o_avail(o_rx_cell_avail)
   );

   ////////////////////////////////////////////////////////////////////////
   // assertions
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!rst_n);

   flush_empty_a: assert property (rx_flush |=> f.count == 3'h0)
      else $error("fifo not empty under flush");
   flush_block_a: assert property (rx_flush |-> !f.hdr_we && !f.pay_we)
      else $error("fifo written under flush");
   descr_off_a: assert property (f.pay_we && ctrl[bit_descr_off] |-> f.pay_data == i_cell_byte)
      else $error("payload altered with descrambler off");
   coset_off_a: assert property (cell_dec && clean && !ctrl[bit_coset]
                                 |-> hdr_now[7:0] == crc8(hdr_now[39:8]))
      else $error("header passed without matching check octet");
   uncorr_drop_a: assert property (cell_dec && !clean && !correctable && !ctrl[bit_pass]
                                   |=> !keep)
      else $error("uncorrectable cell kept");
   pass_hold_a: assert property (cell_dec && ctrl[bit_pass] |=> mode == correct_mode)
      else $error("left correction mode with pass set");
   sync_only_a: assert property (f.hdr_we |-> delin == sync && idx == hec_idx)
      else $error("cell written outside sync");
   corr_off_a: assert property (ctrl[bit_corr_off] |-> !correctable)
      else $error("correction while disabled");
   idle_drop_a: assert property (cell_dec && idle && !ctrl[bit_bypass] |-> !f.hdr_we)
      else $error("idle cell written");
   ood_read_a: assert property (setup && !i_pwrite && widx == idx_ctrl
                                |=> o_prdata[7] == ($past(delin) != sync))
      else $error("delineation status wrong");
   ovr_flag_a: assert property (ovr_evt |=> flags[0])
      else $error("overrun not flagged");
   read_clear_a: assert property (rd_acc && flags_seen[2] && !flag_set[2] |=> !flags[2])
      else $error("flag not cleared by read");
   delin_flag_a: assert property (delin == sync && $past(delin) == presync |-> flags[3])
      else $error("sync entry not flagged");
   irq_on_a: assert property (irq_en == 3'h7 && flags != 4'h0 |=> o_irq)
      else $error("enabled flag gives no interrupt");
   detect_drop_a: assert property (cell_dec && mode == detect_mode && !clean
                                   && !ctrl[bit_pass] |-> !accept)
      else $error("errored cell accepted in detection mode");
   count_a: assert property (f.commit && !rd_acc |=> cell_count == $past(cell_count) + 19'h1)
      else $error("committed cell not counted");

   sync_c: cover property (delin == presync ##1 delin == sync);
   commit_c: cover property (f.commit);
   overrun_c: cover property (ovr_evt);
   corr_c: cover property (cell_dec && corr_evt && accept);
endmodule // rx_atm_cell_processor
`default_nettype wire

// >>> rx_atm_cell_processor_tb.sv
// testbench: registers, delineation, filter, header check and fifo
`timescale 1ns/1ns
`default_nettype none
module rx_atm_cell_processor_tb;
   localparam logic [31:0] user = 32'h00000010;
   logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000, prdata, q;
   logic [7:0] cb = 8'h00, rbus;
   logic cv = 1'b0, go = 1'b0, slow = 1'b0;
   logic pready, pslverr, se, rd, par, vld, avail, irq, done;
   int n_errors = 0;
   int samples_checked = 0;
   always #10 clk = ~clk;
   rx_atm_cell_processor u_rx_atm_cell_processor (.i_clk(clk), .i_reset_n(rst_n),
      .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
      .i_pstrb(4'hf), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
      .i_cell_byte(cb), .i_cell_valid(cv), .i_rx_read(rd), .o_rx_cell_bus(rbus),
      .o_rx_parity_out(par), .o_rx_valid(vld), .o_rx_start_of_cell(), .o_rx_cell_avail(avail),
      .o_irq(irq));
   atm_layer_model u_atm_layer_model (.i_clk(clk), .i_go(go), .i_slow(slow), .i_avail(avail),
      .i_data(rbus), .i_parity(par), .i_valid(vld), .o_read(rd), .o_done(done));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic close_out();
      $display("errors %0d checks %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic bound(input int k, input int lim);
      if (k >= lim) begin
         n_errors++;
         close_out();
      end
   endtask
   task automatic look();
      repeat (4) @(negedge clk);
   endtask
   // every driver waits a rising edge first, so no signal is set twice in one step
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      int k;
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge clk);
      pen <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      q = prdata;
      se = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      bound(k, 50);
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 8'h00);
      chk(q, e);
   endtask
   function automatic logic [39:0] hdr(input logic [31:0] h);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 31; i >= 0; i--) begin
         c = {c[6:0], 1'b0} ^ ((c[7] ^ h[i]) ? 8'h07 : 8'h00);
      end
      return {h, c ^ 8'h55};
   endfunction
   task automatic cells(input logic [31:0] h, input int fl, input int num);
      logic [39:0] x;
      x = hdr(h);
      if (fl >= 0) x[fl] = ~x[fl];
      @(posedge clk);
      for (int c = 0; c < num * 53; c++) begin
         cv <= 1'b1;
         cb <= (c % 53 < 5) ? x[39 - 8 * (c % 53) -: 8] : 8'(c % 53);
         @(posedge clk);
      end
      cv <= 1'b0;
   endtask
   task automatic pop(input logic [31:0] h, input logic pe);
      logic [39:0] x;
      int k;
      x = hdr(h);
      @(posedge clk);
      go <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (done !== 1'b1 && k < 400);
      bound(k, 400);
      for (int i = 0; i < 53; i++) begin
         chk(32'(u_atm_layer_model.rx[i]), 32'((i < 5) ? x[39 - 8 * i -: 8] : 8'(i)));
         chk(32'(u_atm_layer_model.par[i]), 32'((~^u_atm_layer_model.rx[i]) ^ pe));
      end
      go <= 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      rdc(12'h140, 32'h84);
      rdc(12'h144, 32'h0);
      rdc(12'h148, 32'h0);
      rdc(12'h14c, 32'h0);
      rdc(12'h1f0, 32'h0);
      chk(32'(se), 32'h1);
   endtask
   task automatic t_sync();
      apb(1'b1, 12'h144, 8'he0);
      apb(1'b1, 12'h140, 8'h06);
      cells(user, -1, 8);
      look();
      chk(32'(irq), 32'h1);
      rdc(12'h144, 32'hf0);
      look();
      chk(32'(irq), 32'h0);
      rdc(12'h140, 32'h06);
      apb(1'b0, 12'h16c, 8'h00);
      apb(1'b1, 12'h140, 8'h07);
      cells(user, -1, 1);
      look();
      chk(32'(avail), 32'h0);
      rdc(12'h16c, 32'h0);
      apb(1'b1, 12'h140, 8'h06);
   endtask
   task automatic t_filter();
      cells(32'h0, -1, 1);
      cells(user, -1, 1);
      rdc(12'h16c, 32'h1);
      pop(user, 1'b0);
      apb(1'b1, 12'h140, 8'h26);
      cells(32'h0, -1, 1);
      rdc(12'h16c, 32'h1);
      apb(1'b1, 12'h140, 8'h06);
      apb(1'b1, 12'h14c, 8'h01);
      apb(1'b1, 12'h148, 8'h01);
      cells(32'h0, -1, 1);
      cells(32'h1, -1, 1);
      rdc(12'h16c, 32'h1);
   endtask
   task automatic t_hdr();
      apb(1'b1, 12'h140, 8'h47);
      apb(1'b1, 12'h140, 8'h46);
      cells(user, 39, 1);
      cells(user, -1, 1);
      rdc(12'h144, 32'he8);
      rdc(12'h16c, 32'h2);
      slow <= 1'b1;
      pop(user, 1'b1);
      apb(1'b1, 12'h140, 8'h56);
      cells(user, 39, 1);
      cells(user, -1, 1);
      rdc(12'h144, 32'he4);
      rdc(12'h16c, 32'h1);
      // errored cell kept once pass is on
      apb(1'b1, 12'h140, 8'h5e);
      cells(user, 39, 1);
      rdc(12'h16c, 32'h1);
      rdc(12'h144, 32'he4);
   endtask
   task automatic t_overrun();
      apb(1'b1, 12'h140, 8'h07);
      apb(1'b1, 12'h140, 8'h06);
      apb(1'b1, 12'h144, 8'h40);
      cells(user, -1, 5);
      look();
      chk(32'(avail), 32'h1);
      chk(32'(irq), 32'h0);
      rdc(12'h144, 32'h42);
      rdc(12'h16c, 32'h4);
   endtask
   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      t_reset();
      t_sync();
      t_filter();
      t_hdr();
      t_overrun();
      close_out();
   end
endmodule // rx_atm_cell_processor_tb
`default_nettype wire
